// ===== hw/oma_arbiter.sv
// Operation mode arbiter: panel, external and host command source selection
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module oma_arbiter #(
	parameter int SPEED_W = oma_pkg::SPEED_W,
	parameter int N_TERM = oma_pkg::N_TERM
) (
	input wire logic clk,
	input wire logic rst_b,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Command sources
	input wire oma_pkg::oma_req_t req,
	input wire logic comm_option_present,
	input wire logic [N_TERM-1:0] terminals,
	input wire logic forward_start_input,
	input wire logic reverse_start_input,
	input wire logic [SPEED_W-1:0] ext_speed,
	input wire logic ext_speed_valid,
	input wire logic panel_unit_operation,
	input wire oma_pkg::oma_cmd_t panel_cmd,
	input wire logic host_cmd_valid,
	input wire oma_pkg::oma_cmd_t host_cmd,
	// Drive side
	output logic [2:0] mode,
	output oma_pkg::oma_cmd_t drive_cmd,
	output logic drive_run,
	output logic output_stop
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic sel_valid(input logic [3:0] s);
		sel_valid = (s <= oma_pkg::SEL_MAX) && (s != oma_pkg::SEL_UNUSED);
	endfunction

	function automatic oma_pkg::oma_cmd_t ext_cmd(input logic f, input logic r, input logic [SPEED_W-1:0] sp);
		ext_cmd.fwd = f & ~r;
		ext_cmd.rev = r & ~f;
		ext_cmd.speed = sp;
	endfunction

	// ****************************************************************
	// Registers and interlock input
	// ****************************************************************
	logic [3:0] mode_select_setting_q;
	logic [2:0] term_sel_q;
	logic il_level;
	logic il_rise;
	logic il_fall;

	oma_term_sel #(
		.N(N_TERM)
	) u_term_sel (
		.clk(clk),
		.rst_b(rst_b),
		.terminals(terminals),
		.sel(term_sel_q),
		.level(il_level),
		.rise(il_rise),
		.fall(il_fall)
	);

	logic il_mode;
	logic sw_mode;
	logic start_any;
	assign il_mode = (mode_select_setting_q == oma_pkg::SEL_INTERLOCK);
	assign sw_mode = (mode_select_setting_q == oma_pkg::SEL_SWITCHOVER);
	assign start_any = forward_start_input | reverse_start_input;

	// ****************************************************************
	// Mode state
	// ****************************************************************
	oma_pkg::oma_mode_t mode_q;
	oma_pkg::oma_mode_t mode_d;
	logic run_q;

	always_comb begin
		mode_d = mode_q;
		if (il_mode) begin
			if (!il_level) begin
				mode_d = oma_pkg::OMA_EXT;
			end else begin
				unique case (mode_q)
					oma_pkg::OMA_EXT: begin
						if (req.panel_pu && !start_any) begin
							mode_d = oma_pkg::OMA_PU;
						end
					end
					oma_pkg::OMA_PU: begin
						if (req.panel_ext) begin
							mode_d = oma_pkg::OMA_EXT;
						end
					end
					oma_pkg::OMA_LINK: begin
						mode_d = oma_pkg::OMA_EXT;
					end
				endcase
			end
		end else if (sw_mode) begin
			unique case (mode_q)
				oma_pkg::OMA_EXT: begin
					if (req.panel_pu) begin
						mode_d = oma_pkg::OMA_PU;
					end else if (req.host_link && comm_option_present) begin
						mode_d = oma_pkg::OMA_LINK;
					end
				end
				oma_pkg::OMA_PU: begin
					if (req.panel_ext) begin
						mode_d = oma_pkg::OMA_EXT;
					end else if (req.host_link && comm_option_present) begin
						mode_d = oma_pkg::OMA_LINK;
					end
				end
				oma_pkg::OMA_LINK: begin
					if (req.host_ext) begin
						mode_d = oma_pkg::OMA_EXT;
					end else if (req.panel_pu) begin
						mode_d = oma_pkg::OMA_PU;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= oma_pkg::OMA_EXT;
		end else begin
			mode_q <= mode_d;
		end
	end

	// ****************************************************************
	// Held command and carried speed
	// ****************************************************************
	oma_pkg::oma_cmd_t hold_q;
	logic [SPEED_W-1:0] carry_q;
	logic carry_valid_q;
	oma_pkg::oma_cmd_t ext_now;
	assign ext_now = ext_cmd(forward_start_input, reverse_start_input, ext_speed);

	// While external, track inputs so any later change carries them over
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_q <= '0;
		end else if (mode_q == oma_pkg::OMA_EXT) begin
			hold_q.fwd <= ext_now.fwd;
			hold_q.rev <= ext_now.rev;
			hold_q.speed <= carry_valid_q ? carry_q : hold_q.speed;
		end else if (mode_q == oma_pkg::OMA_PU && panel_unit_operation) begin
			hold_q <= panel_cmd;
		end else if (mode_q == oma_pkg::OMA_LINK && host_cmd_valid) begin
			hold_q <= host_cmd;
		end
	end

	// Lost on reset, which is also what power removal looks like here
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			carry_q <= oma_pkg::SPEED_RESET;
			carry_valid_q <= 1'b0;
		end else if (mode_q == oma_pkg::OMA_EXT && ext_speed_valid) begin
			carry_q <= ext_speed;
			carry_valid_q <= 1'b1;
		end
	end

	// ****************************************************************
	// Interlock stop and stopped-hold
	// ****************************************************************
	logic stop_hold_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stop_hold_q <= 1'b0;
		end else if (il_mode && il_fall && mode_q == oma_pkg::OMA_PU && !run_q) begin
			stop_hold_q <= 1'b1;
		end else if (!start_any || mode_q != oma_pkg::OMA_EXT) begin
			stop_hold_q <= 1'b0;
		end
	end

	logic stop_d;
	// Interlock on in external blocks output; the level drives it both ways
	assign stop_d = il_mode && il_level && (mode_q == oma_pkg::OMA_EXT);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			output_stop <= 1'b0;
		end else begin
			output_stop <= stop_d;
		end
	end

	// ****************************************************************
	// Command out
	// ****************************************************************
	oma_pkg::oma_cmd_t cmd_d;

	always_comb begin
		unique case (mode_q)
			oma_pkg::OMA_EXT: begin
				cmd_d = ext_now;
			end
			oma_pkg::OMA_PU: begin
				cmd_d = hold_q;
			end
			oma_pkg::OMA_LINK: begin
				cmd_d = hold_q;
			end
			default: begin
				cmd_d = '0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			drive_cmd <= '0;
		end else begin
			drive_cmd <= cmd_d;
		end
	end

	// External run after an interlock fall needs both speed and start
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			run_q <= 1'b0;
		end else begin
			run_q <= (cmd_d.fwd | cmd_d.rev) && !stop_d && !stop_hold_q
				&& (mode_q != oma_pkg::OMA_EXT || carry_valid_q || ext_speed_valid);
		end
	end

	assign drive_run = run_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode <= oma_pkg::OMA_EXT;
		end else begin
			mode <= mode_d;
		end
	end

	// ****************************************************************
	// Avalon-MM slave
	// ****************************************************************
	logic req_any;
	logic take;
	assign req_any = avs_read | avs_write;
	// One wait cycle per access; data is staged while waitrequest is high
	assign take = req_any & ~avs_waitrequest;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~(req_any & avs_waitrequest);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_select_setting_q <= oma_pkg::SEL_RESET;
			term_sel_q <= oma_pkg::TERM_RESET;
		end else if (take && avs_write && avs_address == oma_pkg::ADDR_CTRL) begin
			// Out of range settings are refused as a whole word
			if (sel_valid(avs_writedata[oma_pkg::CTRL_SEL_LSB +: oma_pkg::CTRL_SEL_W])) begin
				mode_select_setting_q <= avs_writedata[oma_pkg::CTRL_SEL_LSB +: oma_pkg::CTRL_SEL_W];
				term_sel_q <= avs_writedata[oma_pkg::CTRL_TERM_LSB +: oma_pkg::CTRL_TERM_W];
			end
		end
	end

	logic [31:0] rd_d;

	always_comb begin
		rd_d = 32'h0000_0000;
		unique case (avs_address)
			oma_pkg::ADDR_CTRL: begin
				rd_d[oma_pkg::CTRL_SEL_LSB +: oma_pkg::CTRL_SEL_W] = mode_select_setting_q;
				rd_d[oma_pkg::CTRL_TERM_LSB +: oma_pkg::CTRL_TERM_W] = term_sel_q;
			end
			oma_pkg::ADDR_STATUS: begin
				rd_d[oma_pkg::STAT_MODE_LSB +: 3] = mode_q;
				rd_d[oma_pkg::STAT_STOP_BIT] = output_stop;
				rd_d[oma_pkg::STAT_IL_BIT] = il_level;
				rd_d[oma_pkg::STAT_RUN_BIT] = run_q;
				rd_d[oma_pkg::STAT_HOLD_BIT] = stop_hold_q;
				rd_d[oma_pkg::STAT_CARRY_BIT] = carry_valid_q;
			end
			oma_pkg::ADDR_SPEED: begin
				rd_d[SPEED_W-1:0] = drive_cmd.speed;
			end
			oma_pkg::ADDR_CARRY: begin
				rd_d[SPEED_W-1:0] = carry_q;
			end
			default: begin
				rd_d = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rd_d;
		end
	end

	logic unused_ok;
	assign unused_ok = il_rise;

endmodule
`default_nettype wire

// ===== hw/oma_pkg.sv
// Package: constants, types and register map of the operation mode arbiter
package oma_pkg;

	// ****************************************************************
	// Register map (byte addresses, one 32-bit word each)
	// ****************************************************************
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_SPEED = 4'h8;
	localparam logic [3:0] ADDR_CARRY = 4'hc;

	// Control word fields
	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_SEL_W = 4;
	localparam int CTRL_TERM_LSB = 8;
	localparam int CTRL_TERM_W = 3;

	// Status word fields
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_STOP_BIT = 4;
	localparam int STAT_IL_BIT = 5;
	localparam int STAT_RUN_BIT = 6;
	localparam int STAT_HOLD_BIT = 7;
	localparam int STAT_CARRY_BIT = 8;

	// ****************************************************************
	// Mode selection codes and reset values
	// ****************************************************************
	localparam logic [3:0] SEL_SWITCHOVER = 4'h6;
	localparam logic [3:0] SEL_INTERLOCK = 4'h7;
	localparam logic [3:0] SEL_MAX = 4'h8;
	localparam logic [3:0] SEL_UNUSED = 4'h5;
	localparam logic [3:0] SEL_RESET = 4'h0;
	localparam logic [2:0] TERM_RESET = 3'h0;
	localparam logic [15:0] SPEED_RESET = 16'h0000;

	localparam int SPEED_W = 16;
	localparam int N_TERM = 8;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		OMA_EXT = 3'b001,
		OMA_PU = 3'b010,
		OMA_LINK = 3'b100
	} oma_mode_t;

	// Direction and speed travel together
	typedef struct packed {
		logic fwd;
		logic rev;
		logic [SPEED_W-1:0] speed;
	} oma_cmd_t;

	// Mode change requests from panel and host, one-cycle pulses
	typedef struct packed {
		logic panel_pu;
		logic panel_ext;
		logic host_link;
		logic host_ext;
	} oma_req_t;

endpackage

// ===== hw/oma_term_sel.sv
// Interlock terminal selector with level and edge outputs
`timescale 1ns/10ps
`default_nettype none
module oma_term_sel #(
	parameter int N = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [N-1:0] terminals,
	input wire logic [$clog2(N)-1:0] sel,
	output logic level,
	output logic rise,
	output logic fall
);

	// ****************************************************************
	// Routing and edges
	// ****************************************************************
	logic level_q;
	logic prev_q;

	// Defaults to on so a released reset does not fake a rising edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			level_q <= 1'b1;
		end else begin
			level_q <= terminals[sel];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_q <= 1'b1;
		end else begin
			prev_q <= level_q;
		end
	end

	assign level = level_q;
	assign rise = level_q & ~prev_q;
	assign fall = ~level_q & prev_q;

endmodule
`default_nettype wire

// ===== dv/oma_arbiter_asserts.sv
// Port checker of the operation mode arbiter
`timescale 1ns/10ps
`default_nettype none
module oma_arbiter_asserts #(
	parameter int N_TERM = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	input wire oma_pkg::oma_req_t req,
	input wire logic comm_option_present,
	input wire logic [N_TERM-1:0] terminals,
	input wire logic forward_start_input,
	input wire logic reverse_start_input,
	input wire logic [2:0] mode,
	input wire logic output_stop
);
	// ****************************************
	// Shadow of the control word
	// ****************************************
	logic [3:0] sel_q;
	logic [2:0] term_q;
	wire logic il = terminals[term_q];
	wire logic s6 = sel_q == 4'h6;
	wire logic s7 = sel_q == 4'h7;
	wire logic run_req = forward_start_input | reverse_start_input;
	// Refused settings leave the shadow alone, like the design
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_q <= 4'h0;
			term_q <= 3'h0;
		end else if (avs_write && !avs_waitrequest && avs_address == 4'h0 &&
			avs_writedata[3:0] != 4'h5 && avs_writedata[3:0] <= 4'h8) begin
			sel_q <= avs_writedata[3:0];
			term_q <= avs_writedata[10:8];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_bus_ans;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_bus_ans: assert property (p_bus_ans) else $error("bus access not answered");
	property p_wait_one;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
	property p_onehot;
		mode == 3'h1 || mode == 3'h2 || mode == 3'h4;
	endproperty
	a_onehot: assert property (p_onehot) else $error("mode not one-hot");
	property p_freeze;
		!s6 && !s7 |=> $stable(mode);
	endproperty
	a_freeze: assert property (p_freeze) else $error("mode moved outside switchover");
	property p_pu_take;
		s6 && mode == 3'h1 && req.panel_pu |=> mode == 3'h2;
	endproperty
	a_pu_take: assert property (p_pu_take) else $error("panel request not taken");
	property p_link_opt;
		s6 && req == 4'h2 && !comm_option_present |=> $stable(mode);
	endproperty
	a_link_opt: assert property (p_link_opt) else $error("link taken without option");
	property p_il_force;
		(s7 && !il) [*4] |-> mode == 3'h1 && !output_stop;
	endproperty
	a_il_force: assert property (p_il_force) else $error("interlock off not forcing");
	property p_stop;
		(s7 && il && mode == 3'h1) [*4] |-> output_stop;
	endproperty
	a_stop: assert property (p_stop) else $error("no output stop");
	property p_refuse;
		s7 && mode == 3'h1 && run_req && req.panel_pu |=> mode == 3'h1;
	endproperty
	a_refuse: assert property (p_refuse) else $error("panel taken while started");
	c_link: cover property (mode == 3'h4);
	c_stop: cover property (output_stop);
	c_refuse: cover property (s7 && run_req && req.panel_pu);
endmodule
`default_nettype wire

// ===== dv/oma_far_side.sv
// Model of panel, external terminals and host
`timescale 1ns/10ps
`default_nettype none
module oma_far_side (
	input wire logic clk,
	output oma_pkg::oma_req_t req,
	output logic [7:0] terminals,
	output logic forward_start_input,
	output logic reverse_start_input,
	output logic ext_speed_valid,
	output logic [15:0] ext_speed,
	output logic panel_unit_operation,
	output oma_pkg::oma_cmd_t panel_cmd,
	output logic host_cmd_valid,
	output oma_pkg::oma_cmd_t host_cmd
);
	initial begin
		req = '0;
		terminals = 8'hff;
		forward_start_input = 1'b0;
		reverse_start_input = 1'b0;
		ext_speed_valid = 1'b0;
		ext_speed = 16'h0000;
		panel_unit_operation = 1'b0;
		panel_cmd = '0;
		host_cmd_valid = 1'b0;
		host_cmd = '0;
	end
	// ****************************************
	// Panel keys, host commands and external terminals
	// ****************************************
	task automatic pulse(input logic [3:0] r);
		@(posedge clk);
		req <= r;
		@(posedge clk);
		req <= 4'h0;
	endtask
	// Released lines show the inverse so stale loads get caught
	task automatic send(input logic host, input oma_pkg::oma_cmd_t c);
		@(posedge clk);
		host_cmd <= c;
		panel_cmd <= c;
		host_cmd_valid <= host;
		panel_unit_operation <= !host;
		@(posedge clk);
		host_cmd_valid <= 1'b0;
		panel_unit_operation <= 1'b0;
		host_cmd <= ~c;
		panel_cmd <= ~c;
	endtask
	task automatic ext(input logic [7:0] t, input logic f, input logic r, input logic v, input logic [15:0] s);
		@(posedge clk);
		terminals <= t;
		forward_start_input <= f;
		reverse_start_input <= r;
		ext_speed_valid <= v;
		ext_speed <= s;
	endtask
endmodule
`default_nettype wire

// ===== dv/test_drive_operation_mode_arbiter.sv
// Testbench of the operation mode arbiter
`timescale 1ns/10ps
`default_nettype none
module test_drive_operation_mode_arbiter;
	localparam logic [2:0] EXT = 3'h1;
	localparam logic [2:0] PU = 3'h2;
	localparam logic [2:0] LNK = 3'h4;
	logic clk;
	logic rst_b;
	logic [3:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic comm_option_present;
	logic [31:0] rd;
	oma_pkg::oma_req_t req;
	oma_pkg::oma_cmd_t panel_cmd;
	oma_pkg::oma_cmd_t host_cmd;
	oma_pkg::oma_cmd_t drive_cmd;
	logic [7:0] terminals;
	logic forward_start_input;
	logic reverse_start_input;
	logic ext_speed_valid;
	logic [15:0] ext_speed;
	logic panel_unit_operation;
	logic host_cmd_valid;
	logic [2:0] mode;
	logic drive_run;
	logic output_stop;
	int miscompares;
	int cmp_count;
	int cyc;
	oma_far_side u_oma_far_side (.*);
	oma_arbiter u_oma_arbiter (.*);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			give_verdict();
		end
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Starts right after an edge and ends at the edge that completes the access
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic go(input logic [3:0] r, input logic [2:0] m);
		u_oma_far_side.pulse(r);
		wt(3);
		chk(32'(mode), 32'(m));
	endtask
	task automatic dc(input logic [17:0] c);
		chk(32'(drive_cmd), 32'(c));
	endtask
	task automatic sd(input logic h, input logic [17:0] c);
		u_oma_far_side.send(h, c);
		wt(3);
	endtask
	task automatic ex(input logic [7:0] t, input logic f, input logic r, input logic v, input logic [15:0] s);
		u_oma_far_side.ext(t, f, r, v, s);
		wt(4);
	endtask
	initial begin
		rst_b = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		comm_option_present = 1'b0;
		miscompares = 0;
		cmp_count = 0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		bus(0, 4'h4, 32'h0);
		chk(32'(rd[2:0]), 32'(EXT));
		bus(0, 4'h2, 32'h0);
		chk(rd, 32'h0);
		bus(1, 4'h0, 32'h0305);
		bus(0, 4'h0, 32'h0);
		chk(rd, 32'h0);
		go(4'h8, EXT);
		bus(1, 4'h0, 32'h6);
		ex(8'hff, 1, 0, 1, 16'h1234);
		bus(0, 4'hc, 32'h0);
		chk(rd, 32'h1234);
		go(4'h8, PU);
		dc(18'h21234);
		ex(8'hff, 0, 1, 1, 16'h2222);
		dc(18'h21234);
		sd(0, 18'h10555);
		dc(18'h10555);
		go(4'h2, PU);
		@(posedge clk);
		comm_option_present <= 1'b1;
		go(4'h2, LNK);
		dc(18'h10555);
		sd(1, 18'h20777);
		go(4'h8, PU);
		dc(18'h20777);
		go(4'h4, EXT);
		dc(18'h12222);
		go(4'h2, LNK);
		ex(8'hff, 1, 0, 1, 16'h3333);
		dc(18'h12222);
		go(4'h1, EXT);
		dc(18'h23333);
		ex(8'hff, 0, 0, 0, 16'h5555);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		bus(0, 4'hc, 32'h0);
		chk(rd, 32'h0);
		bus(1, 4'h0, 32'h0307);
		ex(8'hf7, 0, 0, 1, 16'h4000);
		go(4'h8, EXT);
		ex(8'h08, 0, 0, 1, 16'h4000);
		chk(32'(output_stop), 32'h1);
		ex(8'h08, 1, 0, 1, 16'h4000);
		go(4'h8, EXT);
		ex(8'h08, 0, 0, 1, 16'h4000);
		go(4'h8, PU);
		sd(0, 18'h24000);
		ex(8'h00, 1, 0, 1, 16'h4000);
		chk(32'(mode), 32'(EXT));
		chk(32'(drive_run), 32'h1);
		bus(0, 4'h8, 32'h0);
		chk(rd, 32'h4000);
		ex(8'h08, 1, 0, 1, 16'h4000);
		chk(32'(output_stop), 32'h1);
		ex(8'h00, 1, 0, 1, 16'h4000);
		chk(32'(output_stop), 32'h0);
		chk(32'(drive_run), 32'h1);
		ex(8'h08, 0, 0, 1, 16'h4000);
		go(4'h8, PU);
		sd(0, 18'h00000);
		// Start held through the fall, so only the stop-hold keeps it stopped
		ex(8'h00, 1, 0, 1, 16'h4000);
		chk(32'(mode), 32'(EXT));
		chk(32'(drive_run), 32'h0);
		bus(0, 4'h4, 32'h0);
		chk(32'(rd[oma_pkg::STAT_HOLD_BIT]), 32'h1);
		ex(8'h00, 0, 0, 1, 16'h4000);
		ex(8'h00, 1, 0, 1, 16'h4000);
		chk(32'(drive_run), 32'h1);
		give_verdict();
	end
endmodule
bind oma_arbiter oma_arbiter_asserts #(.N_TERM(N_TERM)) u_oma_arbiter_asserts (.*);
`default_nettype wire
